// ===== core/pdsr_pkg.sv
/*
 * Package for the processor debug status register bank: register
 * offsets, field positions, cause codes and the carrier structs.
 * Assumes a single core clock and a word-wide status register port.
 */
package pdsr_pkg;
	// Register offsets (word indices of the status register space)
	localparam logic [7:0] PDSR_OFF_OSC_TILE_CELL = 8'h07;
	localparam logic [7:0] PDSR_OFF_OSC_TILE_WIRE = 8'h08;
	localparam logic [7:0] PDSR_OFF_OSC_PERIPH_CELL = 8'h09;
	localparam logic [7:0] PDSR_OFF_OSC_PERIPH_WIRE = 8'h0a;
	localparam logic [7:0] PDSR_OFF_MEM_CAPACITY = 8'h0c;
	localparam logic [7:0] PDSR_OFF_SAVED_STATUS = 8'h10;
	localparam logic [7:0] PDSR_OFF_SAVED_PC = 8'h11;
	localparam logic [7:0] PDSR_OFF_SAVED_SP = 8'h12;
	localparam logic [7:0] PDSR_OFF_REGREAD_THREAD = 8'h13;
	localparam logic [7:0] PDSR_OFF_REGREAD_INDEX = 8'h14;
	localparam logic [7:0] PDSR_OFF_IRQ_CAUSE = 8'h15;
	localparam logic [7:0] PDSR_OFF_IRQ_INFO = 8'h16;
	localparam logic [7:0] PDSR_OFF_STOP_MASK = 8'h18;
	localparam logic [7:0] PDSR_OFF_SCRATCH = 8'h20;
	localparam logic [7:0] PDSR_OFF_SCRATCH_LAST = 8'h27;
	localparam logic [7:0] PDSR_OFF_IBREAK = 8'h30;
	localparam logic [7:0] PDSR_OFF_IBREAK_LAST = 8'h33;
	// Saved status word: writable bits (10,9,7,6,4:0); bit 8 is read-only
	localparam logic [10:0] PDSR_STATUS_WMASK = 11'h6df;
	localparam int PDSR_STATUS_ISSUE_BIT = 8;
	// Cause field layout and codes
	localparam int PDSR_CAUSE_LSB = 0;
	localparam int PDSR_THREAD_LSB = 8;
	localparam int PDSR_BPNUM_LSB = 16;
	localparam logic [2:0] PDSR_CAUSE_NONE = 3'h0;
	localparam logic [2:0] PDSR_CAUSE_HOST = 3'h1;
	localparam logic [2:0] PDSR_CAUSE_DBG_CALL = 3'h2;
	localparam logic [2:0] PDSR_CAUSE_IBREAK = 3'h3;
	localparam logic [2:0] PDSR_CAUSE_DWATCH = 3'h4;
	localparam logic [2:0] PDSR_CAUSE_RWATCH = 3'h5;
	// Reset values, memory size and array counts
	localparam logic [31:0] PDSR_RST_WORD = 32'h0;
	localparam logic [15:0] PDSR_RST_OSC = 16'h0;
	localparam logic [31:0] PDSR_MEM_BYTES = 32'h0008_0000;
	localparam int PDSR_NUM_IBREAK = 4;
	localparam int PDSR_NUM_SCRATCH = 8;

	// One status register access from the processor
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pdsr_ps_req_t;

	// Debugger entry reported by the core, with the state to capture
	typedef struct packed {
		logic valid;
		logic [2:0] cause;
		logic [7:0] thread;
		logic [1:0] bpnum;
		logic [31:0] data;
		logic [10:0] status;
		logic [31:0] pc;
		logic [31:0] sp;
	} pdsr_entry_t;

	// One scratch access from the tile configuration side
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] idx;
		logic [31:0] wdata;
	} pdsr_cfg_req_t;
endpackage

// ===== core/pdsr_core.sv
/*
 * Processor debug status register bank for one tile: oscillator count
 * readbacks, memory capacity, debugger entry capture, register-read
 * operands, thread stop mask, shared scratch and instruction breakpoints.
 * Assumes all inputs are synchronous to core_clk_i, the oscillator ticks
 * arrive as one-cycle pulses, and por_i is asserted only at power-up.
 */
// Summary of operation
// - Oscillator counters cleared only by power-up.
// - Four read-only 16-bit oscillator counts, 0x07-0x0A.
// - Read-only memory capacity at 0x0C, bits 31:2.
// - Debugger entry captures saved status into 0x10.
// - Status bits 0-4: events, interrupts, sequence, handler, kernel.
// - Status bits 6-10: paused, fast, issue, space id.
// - Debugger entry captures saved program counter, 0x11.
// - Debugger entry captures saved stack pointer, 0x12.
// - Register-read thread at 0x13, index at 0x14.
// - Cause code in bits 2:0, reset to zero.
// - Lowest firing breakpoint number; zero for host, call.
// - Causing thread in bits 15:8; zero for host.
// - Watchpoint address or resource id into 0x16.
// - Stop mask at 0x18 blocks threads after return.
// - Eight scratch words shared with configuration space.
// - Four breakpoint addresses; match raises debug interrupt outside debug mode.
// - Condition bit picks equal or not-equal; enable gates.
module pdsr_core
	import pdsr_pkg::*;
#(
	parameter logic [31:0] MEM_BYTES = PDSR_MEM_BYTES
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire pdsr_ps_req_t ps_req_i,
	input wire logic debug_mode_i,
	input wire pdsr_entry_t entry_i,
	input wire pdsr_cfg_req_t cfg_req_i,
	input wire logic [3:0] osc_tick_i,
	input wire logic [3:0] ibreak_en_i,
	input wire logic [3:0] ibreak_cond_i,
	input wire logic pc_valid_i,
	input wire logic [31:0] pc_i,
	input wire logic [7:0] pc_thread_i,
	input wire logic [10:0] pc_status_i,
	input wire logic [31:0] pc_sp_i,
	output logic [31:0] ps_rdata_o,
	output logic ps_rvalid_o,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	output logic [7:0] regread_thread_o,
	output logic [4:0] regread_index_o,
	output logic [7:0] stop_mask_o,
	output logic debug_irq_o,
	output logic [2:0] debug_cause_o
);

	// Lowest set bit of a four-bit vector
	function automatic logic [1:0] lowest_bit(input logic [3:0] v);
		if (v[0]) begin
			return 2'd0;
		end else if (v[1]) begin
			return 2'd1;
		end else if (v[2]) begin
			return 2'd2;
		end
		return 2'd3;
	endfunction

	// Address range check for register groups
	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	logic [15:0] osc_count [4];
	logic [10:0] saved_status;
	logic [31:0] saved_pc;
	logic [31:0] saved_sp;
	logic [7:0] regread_thread;
	logic [4:0] regread_index;
	logic [2:0] irq_cause;
	logic [7:0] irq_thread;
	logic [1:0] irq_bpnum;
	logic [31:0] irq_info;
	logic [7:0] stop_mask;
	logic [31:0] scratch [PDSR_NUM_SCRATCH];
	logic [31:0] instr_break_address [PDSR_NUM_IBREAK];

	// Breakpoint comparison per slot
	wire logic [3:0] ibreak_fire;
	genvar g;
	generate
		for (g = 0; g < PDSR_NUM_IBREAK; g++) begin : g_cmp
			assign ibreak_fire[g] = pc_valid_i && ibreak_en_i[g] && !debug_mode_i &&
				((pc_i == instr_break_address[g]) ^ ibreak_cond_i[g]);
		end
	endgenerate

	// Entry source: the core's report wins over a breakpoint in the same cycle
	wire logic ibreak_take = |ibreak_fire && !entry_i.valid;
	wire logic entry_take = entry_i.valid || ibreak_take;
	wire logic [2:0] next_cause = entry_i.valid ? entry_i.cause : PDSR_CAUSE_IBREAK;
	wire logic cause_host = next_cause == PDSR_CAUSE_HOST;
	wire logic cause_call = next_cause == PDSR_CAUSE_DBG_CALL;
	wire logic [7:0] next_thread = cause_host ? 8'h00 :
		(entry_i.valid ? entry_i.thread : pc_thread_i);
	wire logic [1:0] next_bpnum = (cause_host || cause_call) ? 2'd0 :
		(entry_i.valid ? entry_i.bpnum : lowest_bit(ibreak_fire));
	wire logic data_cause = next_cause == PDSR_CAUSE_DWATCH ||
		next_cause == PDSR_CAUSE_RWATCH;

	// Register write decode; status port writes only take effect in debug mode
	wire logic ps_wr = ps_req_i.valid && ps_req_i.write && debug_mode_i;
	wire logic [7:0] a = ps_req_i.addr;
	wire logic wr_status = ps_wr && a == PDSR_OFF_SAVED_STATUS;
	wire logic wr_pc = ps_wr && a == PDSR_OFF_SAVED_PC;
	wire logic wr_sp = ps_wr && a == PDSR_OFF_SAVED_SP;
	wire logic wr_rthread = ps_wr && a == PDSR_OFF_REGREAD_THREAD;
	wire logic wr_rindex = ps_wr && a == PDSR_OFF_REGREAD_INDEX;
	wire logic wr_cause = ps_wr && a == PDSR_OFF_IRQ_CAUSE;
	wire logic wr_info = ps_wr && a == PDSR_OFF_IRQ_INFO;
	wire logic wr_mask = ps_wr && a == PDSR_OFF_STOP_MASK;
	wire logic wr_scratch = ps_wr && in_range(a, PDSR_OFF_SCRATCH, PDSR_OFF_SCRATCH_LAST);
	wire logic wr_ibreak = ps_wr && in_range(a, PDSR_OFF_IBREAK, PDSR_OFF_IBREAK_LAST);
	wire logic cfg_wr = cfg_req_i.valid && cfg_req_i.write;
	wire logic [2:0] ps_scr_idx = a[2:0];
	wire logic [1:0] ps_bp_idx = a[1:0];

	// Read selection; reserved bits and unmapped offsets read as zero
	logic [31:0] rd_word;
	always_comb begin
		rd_word = PDSR_RST_WORD;
		if (in_range(a, PDSR_OFF_OSC_TILE_CELL, PDSR_OFF_OSC_PERIPH_WIRE)) begin
			rd_word = {16'h0000, osc_count[2'(a - PDSR_OFF_OSC_TILE_CELL)]};
		end else if (a == PDSR_OFF_MEM_CAPACITY) begin
			rd_word = {MEM_BYTES[31:2], 2'b00};
		end else if (a == PDSR_OFF_SAVED_STATUS) begin
			rd_word = {21'h0, saved_status};
		end else if (a == PDSR_OFF_SAVED_PC) begin
			rd_word = saved_pc;
		end else if (a == PDSR_OFF_SAVED_SP) begin
			rd_word = saved_sp;
		end else if (a == PDSR_OFF_REGREAD_THREAD) begin
			rd_word = {24'h0, regread_thread};
		end else if (a == PDSR_OFF_REGREAD_INDEX) begin
			rd_word = {27'h0, regread_index};
		end else if (a == PDSR_OFF_IRQ_CAUSE) begin
			rd_word = {14'h0, irq_bpnum, irq_thread, 5'h00, irq_cause};
		end else if (a == PDSR_OFF_IRQ_INFO) begin
			rd_word = irq_info;
		end else if (a == PDSR_OFF_STOP_MASK) begin
			rd_word = {24'h0, stop_mask};
		end else if (in_range(a, PDSR_OFF_SCRATCH, PDSR_OFF_SCRATCH_LAST)) begin
			rd_word = scratch[ps_scr_idx];
		end else if (in_range(a, PDSR_OFF_IBREAK, PDSR_OFF_IBREAK_LAST)) begin
			rd_word = instr_break_address[ps_bp_idx];
		end
	end

	// Oscillator counters: cleared only at power-up, so a system reset keeps them
	always_ff @(posedge core_clk_i or posedge por_i) begin
		if (por_i) begin
			for (int i = 0; i < 4; i++) begin
				osc_count[i] <= PDSR_RST_OSC;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (osc_tick_i[i]) begin
					osc_count[i] <= osc_count[i] + 16'h0001;
				end
			end
		end
	end

	// Debugger entry capture; the entry wins over a same-cycle software write
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			saved_status <= '0;
			saved_pc <= PDSR_RST_WORD;
			saved_sp <= PDSR_RST_WORD;
		end else if (entry_take) begin
			saved_status <= entry_i.valid ? entry_i.status : pc_status_i;
			saved_pc <= entry_i.valid ? entry_i.pc : pc_i;
			saved_sp <= entry_i.valid ? entry_i.sp : pc_sp_i;
		end else begin
			if (wr_status) begin
				saved_status <= (saved_status & ~PDSR_STATUS_WMASK) |
					(ps_req_i.wdata[10:0] & PDSR_STATUS_WMASK);
			end
			if (wr_pc) begin
				saved_pc <= ps_req_i.wdata;
			end
			if (wr_sp) begin
				saved_sp <= ps_req_i.wdata;
			end
		end
	end

	// Cause, thread and breakpoint number move as one group; data loads only on watchpoint entries
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_cause <= PDSR_CAUSE_NONE;
			irq_thread <= 8'h00;
			irq_bpnum <= 2'd0;
			irq_info <= PDSR_RST_WORD;
		end else if (entry_take) begin
			irq_cause <= next_cause;
			irq_thread <= next_thread;
			irq_bpnum <= next_bpnum;
			if (data_cause) begin
				irq_info <= entry_i.data;
			end
		end else begin
			if (wr_cause) begin
				irq_cause <= ps_req_i.wdata[PDSR_CAUSE_LSB +: 3];
				irq_thread <= ps_req_i.wdata[PDSR_THREAD_LSB +: 8];
				irq_bpnum <= ps_req_i.wdata[PDSR_BPNUM_LSB +: 2];
			end
			if (wr_info) begin
				irq_info <= ps_req_i.wdata;
			end
		end
	end

	// Register-read operands and thread stop mask
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			regread_thread <= 8'h00;
			regread_index <= 5'h00;
			stop_mask <= 8'h00;
		end else begin
			if (wr_rthread) begin
				regread_thread <= ps_req_i.wdata[7:0];
			end
			if (wr_rindex) begin
				regread_index <= ps_req_i.wdata[4:0];
			end
			if (wr_mask) begin
				stop_mask <= ps_req_i.wdata[7:0];
			end
		end
	end

	// Scratch words: one store for both ports, the status port wins a clash
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < PDSR_NUM_SCRATCH; i++) begin
				scratch[i] <= PDSR_RST_WORD;
			end
		end else if (wr_scratch) begin
			scratch[ps_scr_idx] <= ps_req_i.wdata;
		end else if (cfg_wr) begin
			scratch[cfg_req_i.idx] <= cfg_req_i.wdata;
		end
	end

	// Breakpoint addresses
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < PDSR_NUM_IBREAK; i++) begin
				instr_break_address[i] <= PDSR_RST_WORD;
			end
		end else if (wr_ibreak) begin
			instr_break_address[ps_bp_idx] <= ps_req_i.wdata;
		end
	end

	// Registered read answers and outputs
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ps_rdata_o <= PDSR_RST_WORD;
			ps_rvalid_o <= 1'b0;
			cfg_rdata_o <= PDSR_RST_WORD;
			cfg_rvalid_o <= 1'b0;
			debug_irq_o <= 1'b0;
			debug_cause_o <= PDSR_CAUSE_NONE;
		end else begin
			ps_rvalid_o <= ps_req_i.valid && !ps_req_i.write;
			ps_rdata_o <= (ps_req_i.valid && !ps_req_i.write) ? rd_word : PDSR_RST_WORD;
			cfg_rvalid_o <= cfg_req_i.valid && !cfg_req_i.write;
			cfg_rdata_o <= (cfg_req_i.valid && !cfg_req_i.write) ?
				scratch[cfg_req_i.idx] : PDSR_RST_WORD;
			debug_irq_o <= ibreak_take;
			debug_cause_o <= entry_take ? next_cause : debug_cause_o;
		end
	end

	// Mirror the operand and mask registers to the core
	assign regread_thread_o = regread_thread;
	assign regread_index_o = regread_index;
	assign stop_mask_o = stop_mask;

	// Checks
	sequence s_entry;
		entry_take;
	endsequence

	sequence s_bp_only;
		!entry_i.valid && pc_valid_i && !debug_mode_i && ibreak_en_i[0] && !ibreak_cond_i[0]
			&& pc_i == instr_break_address[0];
	endsequence

	AST_BP0_TAKEN: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_bp_only |=> debug_irq_o && irq_cause == PDSR_CAUSE_IBREAK && irq_bpnum == 2'd0)
		else $error("breakpoint 0 match did not raise interrupt");

	AST_COND_NE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pc_valid_i && !debug_mode_i && ibreak_en_i[3] && ibreak_cond_i[3] &&
		pc_i != instr_break_address[3] |-> ibreak_fire[3])
		else $error("not-equal breakpoint did not fire");

	AST_HOST_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
		entry_i.valid && entry_i.cause == PDSR_CAUSE_HOST |=> irq_thread == 8'h00 &&
		irq_bpnum == 2'd0)
		else $error("host entry left thread or number nonzero");

	AST_PC_CAPTURE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		entry_i.valid |=> saved_pc == $past(entry_i.pc) && saved_sp == $past(entry_i.sp))
		else $error("saved pc or sp not captured");

	AST_STATUS_CAPTURE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		entry_i.valid |=> saved_status == $past(entry_i.status))
		else $error("saved status not captured");

	AST_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_entry ##1 (!entry_take && !wr_cause) [*3] |-> $stable(irq_cause) &&
		$stable(irq_thread))
		else $error("cause fields changed without entry or write");

	AST_MASK_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_mask |=> stop_mask_o == $past(ps_req_i.wdata[7:0]))
		else $error("stop mask not written");

	// One idle cycle between the two ports, as a task-driven host produces
	AST_SCRATCH_SHARED: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cfg_wr && !wr_scratch ##1 !cfg_wr && !wr_scratch ##1
		ps_req_i.valid && !ps_req_i.write &&
		a == PDSR_OFF_SCRATCH + {5'h0, $past(cfg_req_i.idx, 2)} && !cfg_wr && !wr_scratch
		|=> ps_rdata_o == $past(cfg_req_i.wdata, 3))
		else $error("scratch not shared between ports");

	AST_MEM_READ: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ps_req_i.valid && !ps_req_i.write && a == PDSR_OFF_MEM_CAPACITY |=>
		ps_rvalid_o && ps_rdata_o[1:0] == 2'b00)
		else $error("capacity read wrong");

	AST_OSC_NORESET: assert property (@(posedge core_clk_i) disable iff (por_i)
		rst_i && !(|osc_tick_i) |=> $stable(osc_count[0]))
		else $error("oscillator count changed by system reset");

endmodule

// ===== dv/pdsr_core_tb.sv
/*
 * Self-checking bench for pdsr_core: a register table loop, then write refusal,
 * oscillator count, debugger entry, breakpoint and shared scratch tests.
 * Assumes core/pdsr_pkg.sv and core/pdsr_core.sv are compiled first.
 */
module pdsr_core_tb
	import pdsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] TB_MEM = 32'h0004_0000;
	typedef struct {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pdsr_row_t;

	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	logic debug_mode_i = 1'b1;
	logic pc_valid_i = 1'b0;
	pdsr_ps_req_t ps_req_i = '0;
	pdsr_entry_t entry_i = '0;
	pdsr_cfg_req_t cfg_req_i = '0;
	logic [3:0] osc_tick_i = '0;
	logic [3:0] ibreak_en_i = '0;
	logic [3:0] ibreak_cond_i = '0;
	logic [31:0] pc_i = '0;
	logic [31:0] pc_sp_i = '0;
	logic [7:0] pc_thread_i = '0;
	logic [10:0] pc_status_i = '0;
	logic [31:0] ps_rdata_o, cfg_rdata_o;
	logic ps_rvalid_o, cfg_rvalid_o, debug_irq_o;
	logic [7:0] regread_thread_o, stop_mask_o;
	logic [4:0] regread_index_o;
	logic [2:0] debug_cause_o;
	int err_total = 0;
	int n_tests = 0;

	// Ordinary cases: write in debug mode, then read back through the mask
	pdsr_row_t rows[15] = '{
		'{8'h11, 32'hdeadbeef, 32'hdeadbeef},
		'{8'h12, 32'h1234abcd, 32'h1234abcd},
		'{8'h13, 32'hffffffff, 32'h000000ff},
		'{8'h14, 32'hffffffff, 32'h0000001f},
		'{8'h10, 32'hffffffff, 32'h000006df},
		'{8'h15, 32'hffffffff, 32'h0003ff07},
		'{8'h16, 32'hcafef00d, 32'hcafef00d},
		'{8'h18, 32'hffffff5a, 32'h0000005a},
		'{8'h20, 32'h01020304, 32'h01020304},
		'{8'h27, 32'h0a0b0c0d, 32'h0a0b0c0d},
		'{8'h30, 32'h00001000, 32'h00001000},
		'{8'h33, 32'h00002000, 32'h00002000},
		'{8'h0c, 32'hffffffff, TB_MEM & 32'hfffffffc},
		'{8'h0b, 32'hffffffff, 32'h00000000},
		'{8'h08, 32'hffffffff, 32'h00000000}
	};

	always #25 core_clk_i = ~core_clk_i;

	pdsr_core #(.MEM_BYTES(TB_MEM)) pdsr_core_i (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i), .ps_req_i(ps_req_i),
		.debug_mode_i(debug_mode_i), .entry_i(entry_i), .cfg_req_i(cfg_req_i),
		.osc_tick_i(osc_tick_i), .ibreak_en_i(ibreak_en_i), .ibreak_cond_i(ibreak_cond_i),
		.pc_valid_i(pc_valid_i), .pc_i(pc_i), .pc_thread_i(pc_thread_i),
		.pc_status_i(pc_status_i), .pc_sp_i(pc_sp_i), .ps_rdata_o(ps_rdata_o),
		.ps_rvalid_o(ps_rvalid_o), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
		.regread_thread_o(regread_thread_o), .regread_index_o(regread_index_o),
		.stop_mask_o(stop_mask_o), .debug_irq_o(debug_irq_o), .debug_cause_o(debug_cause_o)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Requests launch at a falling edge and drop at the next one
	task automatic ps_wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge core_clk_i) ps_req_i = '{1'b1, 1'b1, a, d};
		@(negedge core_clk_i) ps_req_i = '0;
	endtask

	// Read answer stands one cycle, so it is sampled at the dropping edge
	task automatic ps_rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge core_clk_i) ps_req_i = '{1'b1, 1'b0, a, 32'h0};
		@(negedge core_clk_i) ps_req_i = '0;
		chk({31'h0, ps_rvalid_o}, 32'h1, "status read valid");
		chk(ps_rdata_o, e, "status read data");
	endtask

	task automatic cfg_wr(input logic [2:0] i, input logic [31:0] d);
		@(negedge core_clk_i) cfg_req_i = '{1'b1, 1'b1, i, d};
		@(negedge core_clk_i) cfg_req_i = '0;
	endtask

	task automatic cfg_rd(input logic [2:0] i, input logic [31:0] e);
		@(negedge core_clk_i) cfg_req_i = '{1'b1, 1'b0, i, 32'h0};
		@(negedge core_clk_i) cfg_req_i = '0;
		chk({31'h0, cfg_rvalid_o}, 32'h1, "config read valid");
		chk(cfg_rdata_o, e, "config read data");
	endtask

	task automatic enter(input logic [2:0] c, input logic [31:0] d);
		@(negedge core_clk_i) entry_i = '{1'b1, c, 8'h03, 2'h1, d, 11'h5d5, 32'h400 + c, 32'h800 + c};
		@(negedge core_clk_i) entry_i = '0;
	endtask

	// One issued instruction; the break pulse is due one cycle later
	task automatic issue(input logic [31:0] pc, input logic [7:0] th, input logic irq);
		@(negedge core_clk_i);
		pc_valid_i = 1'b1;
		pc_i = pc;
		pc_thread_i = th;
		pc_status_i = 11'h2c3;
		pc_sp_i = pc ^ 32'hffff0000;
		@(negedge core_clk_i) pc_valid_i = 1'b0;
		chk({31'h0, debug_irq_o}, {31'h0, irq}, "break pulse");
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run is about 215 cycles; some fourteen times that (3000 cycles) means a hang
	initial begin
		#(3000 * 50);
		err_total++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		final_report();
	end

	initial begin
		logic [2:0] cc;
		repeat (6) @(negedge core_clk_i);
		rst_i = 1'b0;
		por_i = 1'b0;
		foreach (rows[i]) begin
			ps_wr(rows[i].a, rows[i].d);
			ps_rd(rows[i].a, rows[i].e);
		end
		chk({24'h0, stop_mask_o}, 32'h5a, "stop mask");
		chk({24'h0, regread_thread_o}, 32'hff, "read thread");
		chk({27'h0, regread_index_o}, 32'h1f, "read index");
		$display("test register table done");
		// Writes outside debug mode are dropped
		debug_mode_i = 1'b0;
		ps_wr(8'h11, 32'h0);
		ps_rd(8'h11, 32'hdeadbeef);
		$display("test write refusal done");
		// Counts survive system reset, only power-up clears them
		for (int i = 0; i < 4; i++) begin
			repeat (i + 2) begin
				@(negedge core_clk_i) osc_tick_i = 4'h1 << i;
				@(negedge core_clk_i) osc_tick_i = 4'h0;
			end
		end
		repeat (10) @(negedge core_clk_i);
		for (int i = 0; i < 4; i++)
			ps_rd(8'h07 + 8'(i), 32'(i + 2));
		@(negedge core_clk_i) rst_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		rst_i = 1'b0;
		ps_rd(8'h0a, 32'h5);
		ps_rd(8'h15, 32'h0);
		chk({29'h0, debug_cause_o}, 32'h0, "cause after reset");
		@(negedge core_clk_i) por_i = 1'b1;
		@(negedge core_clk_i) por_i = 1'b0;
		ps_rd(8'h07, 32'h0);
		$display("test oscillator counts done");
		// Cause codes 1 to 5, with field zeroing and data loading per cause
		for (int c = 1; c <= 5; c++) begin
			cc = 3'(c);
			debug_mode_i = 1'b1;
			ps_wr(8'h16, 32'h11111111);
			debug_mode_i = 1'b0;
			enter(cc, 32'ha5a50000 + c);
			ps_rd(8'h15, c == 1 ? 32'(c) : c == 2 ? 32'h300 | c : 32'h10300 | c);
			ps_rd(8'h16, c >= 4 ? 32'ha5a50000 + c : 32'h11111111);
			chk({29'h0, debug_cause_o}, 32'(c), "last cause");
		end
		ps_rd(8'h10, 32'h5d5);
		ps_rd(8'h11, 32'h405);
		ps_rd(8'h12, 32'h805);
		$display("test debugger entry done");
		// Two breakpoints on one address: the lower number must win
		debug_mode_i = 1'b1;
		ps_wr(8'h31, 32'h1000);
		ps_wr(8'h32, 32'h1000);
		// System reset cleared every address, so slot 3 is set up again
		ps_wr(8'h33, 32'h2000);
		debug_mode_i = 1'b0;
		ibreak_en_i = 4'b0110;
		issue(32'h1000, 8'h06, 1'b1);
		ps_rd(8'h15, 32'h00010603);
		ps_rd(8'h10, 32'h2c3);
		ps_rd(8'h11, 32'h1000);
		ps_rd(8'h12, 32'hffff1000);
		issue(32'h1004, 8'h06, 1'b0);
		ibreak_en_i = 4'b0000;
		issue(32'h1000, 8'h06, 1'b0);
		// Slot 0 still holds its reset address of zero
		ibreak_en_i = 4'b0001;
		issue(32'h0, 8'h01, 1'b1);
		ps_rd(8'h15, 32'h00000103);
		ibreak_en_i = 4'b1000;
		ibreak_cond_i = 4'b1000;
		issue(32'h2000, 8'h02, 1'b0);
		issue(32'h2004, 8'h02, 1'b1);
		ps_rd(8'h15, 32'h00030203);
		debug_mode_i = 1'b1;
		issue(32'h2004, 8'h02, 1'b0);
		$display("test breakpoints done");
		// Both ports see one scratch store
		cfg_wr(3'd3, 32'h3333cccc);
		ps_rd(8'h23, 32'h3333cccc);
		ps_wr(8'h25, 32'h5555aaaa);
		cfg_rd(3'd5, 32'h5555aaaa);
		// Word 0 was cleared by the mid-run system reset
		cfg_rd(3'd0, 32'h00000000);
		$display("test shared scratch done");
		final_report();
	end
endmodule
